// [rtl/audio_clock_source_select.sv]
// Sample clock reference selector with APB registers and an interrupt.
// Assumes the four reference inputs are asynchronous pins; APB is on core_clk.
// Assumes software either polls the status word or takes the level interrupt.
//
// Behaviour
// - In automatic mode keep scanning inputs; switch from internal to a valid one.
// - When the reference in use is lost, fall back to internal clock as master.
// - Use the configured preferred input whenever it carries a valid signal.
// - Without a valid preferred input, examine the other inputs in turn.
// - With no valid input at all, run as master from the internal clock.
// - Report no lock, lock or sync for each reference input.
// - Fixed internal mode disables automatic reference switching.
// - While slaved, keep the external rate; host rate requests wait for master.
// - Support up to 192 kHz over MADI with only sixteen channels.
// - At double speed halve the MADI input and output channel counts.
//
// The APB interface to the registers and the address map were left to the implementer.
`include "clk_sel_defines.svh"

module audio_clock_source_select #(
  parameter int unsigned LOCK_TIMEOUT_CYC = `LOCK_TIMEOUT_NS / `CLK_PERIOD_NS
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic madi_ref_in,
  input wire logic word_clock_in,
  input wire logic timecode_option_input,
  input wire logic aux_ref_in,
  output logic [2:0] clock_source,
  output logic master_mode,
  output logic [1:0] rate_speed,
  output logic [6:0] madi_channels,
  output logic irq
);

  clk_sel_pkg::top_state_t q_r;
  clk_sel_pkg::top_state_t q_nxt;

  logic [`NUM_REFS-1:0] ref_pins;
  logic [`NUM_REFS-1:0] locked;
  logic [`NUM_REFS-1:0] synced;
  logic [15:0] period [`NUM_REFS];
  logic [15:0] active_period;
  logic [1:0] cur_idx;
  logic [6:0] channels;

  // ----------------------------------------
  // Reference monitors
  // ----------------------------------------
  // Index order of the monitors follows the source codes: MADI, word, timecode, aux.
  assign ref_pins = {aux_ref_in, timecode_option_input, word_clock_in, madi_ref_in};

  genvar gi;
  generate
    for (gi = 0; gi < `NUM_REFS; gi++) begin : g_mon
      ref_monitor #(
        .TIMEOUT(LOCK_TIMEOUT_CYC)
      ) u_mon (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .ref_in(ref_pins[gi]),
        .match_period(active_period),
        .locked(locked[gi]),
        .synced(synced[gi]),
        .period(period[gi])
      );
    end
  endgenerate

  // Source codes are the monitor index plus one; code zero is the internal clock.
  function automatic clk_sel_pkg::src_t src_of(input logic [1:0] idx);
    src_of = clk_sel_pkg::src_t'({1'b0, idx} + 3'h1);
  endfunction

  // Thresholds sit between nominal periods, so a pitched reference still classifies.
  function automatic clk_sel_pkg::speed_t speed_of(input logic [15:0] per);
    if (per < `QUAD_MAX) begin
      speed_of = clk_sel_pkg::SPD_QUAD;
    end else if (per < `DOUBLE_MAX) begin
      speed_of = clk_sel_pkg::SPD_DOUBLE;
    end else begin
      speed_of = clk_sel_pkg::SPD_SINGLE;
    end
  endfunction

  function automatic logic [15:0] nominal_of(input clk_sel_pkg::speed_t spd);
    case (spd)
      clk_sel_pkg::SPD_DOUBLE: nominal_of = `PER_DOUBLE;
      clk_sel_pkg::SPD_QUAD: nominal_of = `PER_QUAD;
      default: nominal_of = `PER_SINGLE;
    endcase
  endfunction

  // The index is only meaningful while slaved; in master mode it is never used.
  assign cur_idx = 2'(q_r.cur - 3'h1);

  // In master mode sync is judged against the internal nominal period.
  always_comb begin
    if (q_r.st == clk_sel_pkg::SEL_SLAVE) begin
      active_period = period[cur_idx];
    end else begin
      active_period = nominal_of(q_r.rate_req);
    end
  end

  // ----------------------------------------
  // Channel count
  // ----------------------------------------
  // The count is registered, so it trails a change of speed by one cycle.
  channel_limit u_chan (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .speed(q_r.speed),
    .ch56(q_r.ch56),
    .channels(channels)
  );

  // ----------------------------------------
  // Selection, registers and events
  // ----------------------------------------
  logic wr_en;
  logic rd_setup;
  logic mapped;
  logic [2:0] events;
  logic [2:0] w1c;
  logic [7:0] input_state;
  logic [1:0] want;

  assign wr_en = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // Writes to the read-only status word are dropped silently.
  // Only holes in the map raise a slave error.

  always_comb begin
    mapped = 1'b1;
    if (paddr == `REG_CTRL) begin
      mapped = 1'b1;
    end else if (paddr == `REG_RATE) begin
      mapped = 1'b1;
    end else if (paddr == `REG_STATUS) begin
      mapped = 1'b1;
    end else if (paddr == `REG_IRQ_STATUS) begin
      mapped = 1'b1;
    end else if (paddr == `REG_IRQ_MASK) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end

  // ----------------------------------------
  // Input status
  // ----------------------------------------
  // Two bits per input: 0 no lock, 1 lock, 2 sync.
  always_comb begin
    for (int i = 0; i < `NUM_REFS; i++) begin
      input_state[2*i +: 2] = {synced[i], locked[i] && !synced[i]};
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // Selection works on last cycle's lock flags, so a switch to the preferred input lands one cycle after lock.
  // That cycle costs nothing and keeps the lock logic out of the selection path.
  always_comb begin
    q_nxt = q_r;
    events = 3'h0;
    w1c = 3'h0;
    want = pwdata[1:0];

    // Source selection.
    if (q_r.fixed_int) begin
      q_nxt.cur = clk_sel_pkg::SRC_INTERNAL;
      q_nxt.st = clk_sel_pkg::SEL_MASTER;
    end else if (locked[q_r.pref]) begin
      q_nxt.cur = src_of(q_r.pref);
      q_nxt.st = clk_sel_pkg::SEL_SLAVE;
    end else begin
      case (q_r.st)
        clk_sel_pkg::SEL_MASTER: begin
          // The scan pointer walks all inputs, one per cycle, while master.
          q_nxt.scan = q_r.scan + 2'h1;
          if (locked[q_r.scan]) begin
            q_nxt.cur = src_of(q_r.scan);
            q_nxt.st = clk_sel_pkg::SEL_SLAVE;
          end else begin
            q_nxt.cur = clk_sel_pkg::SRC_INTERNAL;
          end
        end
        default: begin
          if (!locked[cur_idx]) begin
            q_nxt.cur = clk_sel_pkg::SRC_INTERNAL;
            q_nxt.st = clk_sel_pkg::SEL_MASTER;
            q_nxt.scan = cur_idx + 2'h1;
            events[`EV_LOST] = 1'b1;
          end
        end
      endcase
    end
    // Any change of source, lost or preferred, raises the source-change event.
    if (q_nxt.cur != q_r.cur) begin
      events[`EV_SRC] = 1'b1;
    end

    // Effective rate: the external one while slaved, the request while master.
    if (q_nxt.st == clk_sel_pkg::SEL_SLAVE) begin
      q_nxt.speed = speed_of(period[2'(q_nxt.cur - 3'h1)]);
    end else begin
      q_nxt.speed = q_r.rate_req;
    end

    // Register writes take effect at the access cycle.
    if (wr_en) begin
      if (paddr == `REG_CTRL) begin
        q_nxt.fixed_int = pwdata[`CTRL_FIXED];
        q_nxt.pref = pwdata[`CTRL_PREF_HI:`CTRL_PREF_LO];
        q_nxt.ch56 = pwdata[`CTRL_56CH];
      end else if (paddr == `REG_RATE) begin
        // Codes above quad speed are held at quad, the 192 kHz ceiling.
        if (want > 2'(clk_sel_pkg::SPD_QUAD)) begin
          want = 2'(clk_sel_pkg::SPD_QUAD);
        end
        q_nxt.rate_req = clk_sel_pkg::speed_t'(want);
        if (q_r.st == clk_sel_pkg::SEL_SLAVE && want != 2'(q_r.speed)) begin
          events[`EV_REFUSED] = 1'b1;
        end
      end else if (paddr == `REG_IRQ_STATUS) begin
        w1c = pwdata[2:0];
      end else if (paddr == `REG_IRQ_MASK) begin
        q_nxt.irq_mask = pwdata[2:0];
      end
    end
    // A new event in the clearing cycle survives the clear.
    q_nxt.irq_st = (q_r.irq_st & ~w1c) | events;

    // Read data is captured in the setup cycle so prdata comes from a flop.
    if (rd_setup) begin
      q_nxt.prdata = `DATA_ZERO;
      if (paddr == `REG_CTRL) begin
        q_nxt.prdata[`CTRL_FIXED] = q_r.fixed_int;
        q_nxt.prdata[`CTRL_PREF_HI:`CTRL_PREF_LO] = q_r.pref;
        q_nxt.prdata[`CTRL_56CH] = q_r.ch56;
      end else if (paddr == `REG_RATE) begin
        q_nxt.prdata[1:0] = q_r.rate_req;
      end else if (paddr == `REG_STATUS) begin
        q_nxt.prdata[`ST_SRC_HI:0] = q_r.cur;
        q_nxt.prdata[`ST_MASTER] = (q_r.st == clk_sel_pkg::SEL_MASTER);
        q_nxt.prdata[`ST_SPEED_HI:`ST_SPEED_LO] = q_r.speed;
        q_nxt.prdata[`ST_INPUT_LO +: 8] = input_state;
        q_nxt.prdata[`ST_CH_LO +: 7] = channels;
      end else if (paddr == `REG_IRQ_STATUS) begin
        q_nxt.prdata[2:0] = q_r.irq_st;
      end else if (paddr == `REG_IRQ_MASK) begin
        q_nxt.prdata[2:0] = q_r.irq_mask;
      end
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Reset leaves the selector master on the internal clock, so a clock always runs.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      q_r <= '0;
      q_r.pref <= `PREF_RST;
      q_r.irq_st <= `IRQ_RST;
      q_r.irq_mask <= `IRQ_RST;
      q_r.cur <= clk_sel_pkg::SRC_INTERNAL;
      q_r.st <= clk_sel_pkg::SEL_MASTER;
      q_r.rate_req <= clk_sel_pkg::SPD_SINGLE;
      q_r.speed <= clk_sel_pkg::SPD_SINGLE;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign prdata = q_r.prdata;
  // No wait states: every access completes in its first access cycle.
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign clock_source = q_r.cur;
  assign master_mode = (q_r.st == clk_sel_pkg::SEL_MASTER);
  assign rate_speed = q_r.speed;
  // One count serves both MADI directions, which always shrink together.
  assign madi_channels = channels;
  // The interrupt is a level that stays high until software clears or masks the cause.
  assign irq = |(q_r.irq_st & q_r.irq_mask);

endmodule

// [rtl/channel_limit.sv]
// MADI channel count for the current speed class and frame format.
// Assumes speed and format come from logic on core_clk.
`include "clk_sel_defines.svh"

module channel_limit (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire clk_sel_pkg::speed_t speed,
  input wire logic ch56,
  output logic [6:0] channels
);

  clk_sel_pkg::chan_state_t q_r;
  clk_sel_pkg::chan_state_t q_nxt;

  always_comb begin
    q_nxt = q_r;
    case (speed)
      clk_sel_pkg::SPD_SINGLE: q_nxt.ch = ch56 ? `CH_56 : `CH_64;
      clk_sel_pkg::SPD_DOUBLE: q_nxt.ch = ch56 ? (`CH_56 >> 1) : (`CH_64 >> 1);
      default: q_nxt.ch = `CH_QUAD;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign channels = q_r.ch;

endmodule

// [rtl/clk_sel_defines.svh]
// Constants of the sample clock reference selector: offsets, fields, counts.
// Assumes a 200 MHz core_clk; periods are counted in its cycles.
`ifndef CLK_SEL_DEFINES_SVH
`define CLK_SEL_DEFINES_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define REG_CTRL 8'h00
`define REG_RATE 8'h04
`define REG_STATUS 8'h08
`define REG_IRQ_STATUS 8'h0c
`define REG_IRQ_MASK 8'h10

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define CTRL_FIXED 0
`define CTRL_PREF_LO 1
`define CTRL_PREF_HI 2
`define CTRL_56CH 3
`define ST_SRC_HI 2
`define ST_MASTER 3
`define ST_SPEED_LO 4
`define ST_SPEED_HI 5
`define ST_INPUT_LO 8
`define ST_CH_LO 16
`define EV_SRC 0
`define EV_LOST 1
`define EV_REFUSED 2
`define PREF_RST 2'h0
`define IRQ_RST 3'h0
`define DATA_ZERO 32'h0000_0000

// ----------------------------------------
// Lock detection and rate classes
// ----------------------------------------
`define LOCK_TIMEOUT_NS 40960
`define CLK_PERIOD_NS 5
`define LOCK_EDGES 3'h4
`define PER_TOL 16'h0008
`define CNT_ONE 16'h0001
`define CNT_MAX 16'hffff
`define PER_SINGLE 16'h1046
`define PER_DOUBLE 16'h0823
`define PER_QUAD 16'h0411
`define QUAD_MAX 16'h05dc
`define DOUBLE_MAX 16'h0bb8
`define CH_64 7'h40
`define CH_56 7'h38
`define CH_QUAD 7'h10
`define NUM_REFS 4

`endif

// [rtl/clk_sel_pkg.sv]
// Types shared by the sample clock reference selector and its helpers.
// Assumes the constants header is compiled alongside.
package clk_sel_pkg;

  // ----------------------------------------
  // Enumerations
  // ----------------------------------------
  typedef enum logic [2:0] {SRC_INTERNAL, SRC_MADI, SRC_WORD, SRC_TIMECODE, SRC_AUX} src_t;
  typedef enum logic [1:0] {SPD_SINGLE, SPD_DOUBLE, SPD_QUAD} speed_t;
  typedef enum logic {SEL_MASTER, SEL_SLAVE} sel_state_t;

  // ----------------------------------------
  // Module state records
  // ----------------------------------------
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic [15:0] cnt;
    logic [15:0] per;
    logic [2:0] good;
    logic lock;
    logic sync;
  } mon_state_t;

  typedef struct packed {
    logic [6:0] ch;
  } chan_state_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic fixed_int;
    logic [1:0] pref;
    logic ch56;
    speed_t rate_req;
    src_t cur;
    sel_state_t st;
    logic [1:0] scan;
    speed_t speed;
    logic [2:0] irq_st;
    logic [2:0] irq_mask;
  } top_state_t;

endpackage

// [rtl/ref_monitor.sv]
// One reference input monitor: synchroniser, period meter, lock and sync flags.
// Assumes ref_in is asynchronous to core_clk and far slower than it.
`include "clk_sel_defines.svh"

module ref_monitor #(
  parameter int unsigned TIMEOUT = 8192
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic ref_in,
  input wire logic [15:0] match_period,
  output logic locked,
  output logic synced,
  output logic [15:0] period
);

  clk_sel_pkg::mon_state_t q_r;
  clk_sel_pkg::mon_state_t q_nxt;

  function automatic logic [15:0] absdiff(input logic [15:0] a, input logic [15:0] b);
    absdiff = (a > b) ? a - b : b - a;
  endfunction

  // ----------------------------------------
  // Edge period tracking
  // ----------------------------------------
  always_comb begin
    q_nxt = q_r;
    q_nxt.s1 = ref_in;
    q_nxt.s2 = q_r.s1;
    q_nxt.s3 = q_r.s2;
    if (q_r.cnt != `CNT_MAX) begin
      q_nxt.cnt = q_r.cnt + `CNT_ONE;
    end
    if (q_r.s2 && !q_r.s3) begin
      q_nxt.cnt = `CNT_ONE;
      q_nxt.per = q_r.cnt;
      if (absdiff(q_r.cnt, q_r.per) <= `PER_TOL) begin
        if (q_r.good != `LOCK_EDGES) begin
          q_nxt.good = q_r.good + 3'h1;
        end
      end else begin
        q_nxt.good = 3'h0;
      end
    end else if (q_r.cnt >= TIMEOUT[15:0]) begin
      // A silent input drops lock without waiting for another edge.
      q_nxt.good = 3'h0;
    end
    q_nxt.lock = (q_nxt.good == `LOCK_EDGES);
    q_nxt.sync = q_nxt.lock && (absdiff(q_nxt.per, match_period) <= `PER_TOL);
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign locked = q_r.lock;
  assign synced = q_r.sync;
  assign period = q_r.per;

endmodule

// [tb/clk_sel_chk.sv]
// Port checker of the clock reference selector.
// Assumes it is bound to audio_clock_source_select on core_clk.
`include "clk_sel_defines.svh"
module clk_sel_chk (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [2:0] clock_source,
  input wire logic master_mode,
  input wire logic [1:0] rate_speed,
  input wire logic [6:0] madi_channels,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  logic acc;
  logic bad;
  assign acc = psel && penable;
  assign bad = !(paddr inside {`REG_CTRL, `REG_RATE, `REG_STATUS, `REG_IRQ_STATUS, `REG_IRQ_MASK});
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_no_wait: assert property (acc |-> pready) else $error("ready low in access");
  a_err_unmapped: assert property (acc && bad |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  a_err_only: assert property (pslverr |-> acc && bad) else $error("stray slave error");
  a_src_master: assert property (master_mode == (clock_source == 3'h0))
    else $error("master flag and source disagree");
  a_src_legal: assert property (clock_source <= 3'h4 && rate_speed != 2'h3)
    else $error("illegal source or speed code");
  a_quad_chan: assert property ($stable(rate_speed) && rate_speed == 2'h2 |->
    madi_channels == 7'h10) else $error("quad speed channel count");
  a_double_chan: assert property ($stable(rate_speed) && rate_speed == 2'h1 |->
    madi_channels inside {7'h20, 7'h1c}) else $error("double speed channel count");
  a_rate_held: assert property (acc && pwrite && paddr == `REG_RATE && !master_mode |=>
    ##1 (master_mode || $stable(rate_speed))) else $error("rate changed while slave");
  a_fixed_int: assert property (acc && pwrite && paddr == `REG_CTRL && pwdata[0] |->
    ##[1:4] master_mode && clock_source == 3'h0) else $error("fixed mode not internal");
  a_mask_off: assert property (acc && pwrite && paddr == `REG_IRQ_MASK && pwdata[2:0] == 3'h0
    |=> !irq) else $error("irq with all masked");
  c_quad: cover property (!master_mode && rate_speed == 2'h2);
  c_double: cover property (!master_mode && rate_speed == 2'h1);
  c_refused: cover property (acc && pwrite && paddr == `REG_RATE && !master_mode);
endmodule

bind audio_clock_source_select clk_sel_chk i_chk (.core_clk(core_clk), .sys_rst(sys_rst),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .clock_source(clock_source),
  .master_mode(master_mode), .rate_speed(rate_speed), .madi_channels(madi_channels),
  .irq(irq));

// [tb/ref_source_model.sv]
// Far-side reference clocks: MADI, word, timecode option, auxiliary.
// Assumes two mode bits per source: 0 stopped, 1 160 ns, 2 10 us, 3 20 us.
module ref_source_model (
  input wire logic [7:0] mode,
  output logic [3:0] refs
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Sources
  // ----------------------------------------
  // A stopped source stands still low; mode changes land at the next half period.
  for (genvar i = 0; i < 4; i++) begin : g_src
    int hp;
    initial begin
      refs[i] = 1'b0;
      forever begin
        hp = (mode[2*i +: 2] == 2'h2) ? 5000 : (mode[2*i +: 2] == 2'h3) ? 10000 : 80;
        refs[i] = (mode[2*i +: 2] == 2'h0) ? 1'b0 : ~refs[i];
        #(hp);
      end
    end
  end
endmodule

// [tb/testbench.sv]
// Self-checking bench of the clock reference selector.
// Assumes the design and the reference source model are compiled first.
`include "clk_sel_defines.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Harness
  // ----------------------------------------
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, master_mode, irq, perr;
  logic [2:0] clock_source;
  logic [1:0] rate_speed;
  logic [6:0] madi_channels;
  logic [7:0] mode = 8'h00;
  logic [3:0] refs;
  logic [31:0] rd;
  logic [31:0] v;
  logic [1:0] spd;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #2.5 core_clk = ~core_clk;
  ref_source_model i_src (.mode(mode), .refs(refs));
  audio_clock_source_select #(.LOCK_TIMEOUT_CYC(6000)) i_dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .madi_ref_in(refs[0]), .word_clock_in(refs[1]), .timecode_option_input(refs[2]),
    .aux_ref_in(refs[3]), .clock_source(clock_source), .master_mode(master_mode),
    .rate_speed(rate_speed), .madi_channels(madi_channels), .irq(irq));
  task automatic stop_test();
    if (err_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Entered just after a rising edge; leaves one idle cycle so no signal is set twice.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk({31'h0, n < 50}, 32'h1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wait_src(input logic [2:0] s);
    int n;
    n = 0;
    while (clock_source !== s && n < 40000) begin
      @(posedge core_clk);
      n++;
    end
    chk({31'h0, n < 40000}, 32'h1);
    repeat (3) @(posedge core_clk);
  endtask
  function automatic logic [6:0] exp_ch(input logic [1:0] spd, input logic c56);
    exp_ch = (spd == 2'h2) ? 7'h10 : (spd == 2'h1) ? (c56 ? 7'h1c : 7'h20) : (c56 ? 7'h38 : 7'h40);
  endfunction
  task automatic outs(input logic [2:0] s, input logic [1:0] spd, input logic c56);
    chk({19'h0, clock_source, master_mode, rate_speed, madi_channels},
      {19'h0, s, s == 3'h0, spd, exp_ch(spd, c56)});
  endtask
  // Slowest path is one 10 us and one 20 us lock phase plus three loss timeouts, well below this.
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 100000) begin
      err_count++;
      stop_test();
    end
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    v = $urandom(87);
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    outs(3'h0, 2'h0, 1'b0);
    apb(1'b0, `REG_STATUS, 32'h0);
    chk(rd, 32'h0040_0008);
    for (int i = 0; i < 5; i++) begin
      if (i != 2) begin
        apb(1'b0, 8'(4 * i), 32'h0);
        chk(rd, 32'h0);
      end
    end
    apb(1'b0, 8'h14, 32'h0);
    chk({rd[30:0], perr}, 32'h1);
    for (int i = 0; i < 8; i++) begin
      v = $urandom();
      if (i < 3) v[5:4] = 2'h3 - i[1:0];
      spd = (v[5:4] == 2'h3) ? 2'h2 : v[5:4];
      apb(1'b1, `REG_CTRL, {28'h0, v[3:0]});
      apb(1'b1, `REG_RATE, {30'h0, v[5:4]});
      apb(1'b0, `REG_RATE, 32'h0);
      chk(rd, {30'h0, spd});
      outs(3'h0, spd, v[3]);
    end
    apb(1'b1, `REG_RATE, 32'h0);
    apb(1'b1, `REG_IRQ_MASK, 32'h7);
    apb(1'b1, `REG_CTRL, 32'h2);
    apb(1'b1, `REG_IRQ_STATUS, 32'h7);
    mode <= 8'h01;
    wait_src(3'h1);
    outs(3'h1, 2'h2, 1'b0);
    mode <= 8'h05;
    wait_src(3'h2);
    outs(3'h2, 2'h2, 1'b0);
    apb(1'b0, `REG_STATUS, 32'h0);
    chk(rd, 32'h0010_0a22);
    apb(1'b1, `REG_RATE, 32'h0);
    chk({30'h0, rate_speed}, 32'h2);
    apb(1'b0, `REG_IRQ_STATUS, 32'h0);
    chk({rd[30:0], irq}, 32'hb);
    apb(1'b1, `REG_IRQ_MASK, 32'h0);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, `REG_IRQ_MASK, 32'h7);
    apb(1'b1, `REG_IRQ_STATUS, 32'h7);
    chk({31'h0, irq}, 32'h0);
    mode <= 8'h01;
    wait_src(3'h1);
    outs(3'h1, 2'h2, 1'b0);
    apb(1'b0, `REG_IRQ_STATUS, 32'h0);
    chk(rd, 32'h3);
    apb(1'b1, `REG_CTRL, 32'h1);
    repeat (50) @(posedge core_clk);
    outs(3'h0, 2'h0, 1'b0);
    apb(1'b1, `REG_CTRL, 32'hc);
    mode <= 8'h21;
    wait_src(3'h3);
    outs(3'h3, 2'h1, 1'b1);
    apb(1'b0, `REG_STATUS, 32'h0);
    chk(rd, 32'h001c_2113);
    mode <= 8'hc0;
    wait_src(3'h4);
    outs(3'h4, 2'h0, 1'b1);
    mode <= 8'h00;
    wait_src(3'h0);
    outs(3'h0, 2'h0, 1'b1);
    stop_test();
  end
endmodule
